// file: common/brc_consts.svh
/*
  Constants for the bridge reset controller: register offset, field
  positions, reset values and timing counts.
  Assumes a 10 MHz system clock (100 ns period).
*/
`ifndef BRC_CONSTS_SVH
`define BRC_CONSTS_SVH

`define BRC_CLK_PERIOD_NS      100
// Bridge control register, byte offset in configuration space
`define BRC_BRIDGE_CTL_OFFSET  8'h3e
`define BRC_BRIDGE_CTL_RESET   16'h0000
`define BRC_SEC_RESET_BIT      6
// Power-good threshold, percent of nominal core supply
`define BRC_SUPPLY_GOOD_PCT    8'h5a
// Delay after reference clock activity before releasing power-on reset
`define BRC_CLK_WAIT_NS        10000
`define BRC_CLK_WAIT_CYC       ((`BRC_CLK_WAIT_NS + `BRC_CLK_PERIOD_NS - 1) / `BRC_CLK_PERIOD_NS)
// Longest time from reset release to link training start
`define BRC_TRAIN_MAX_MS       80
`define BRC_TRAIN_MAX_CYC      ((`BRC_TRAIN_MAX_MS * 1000000) / `BRC_CLK_PERIOD_NS)
// Default delay to training start, well inside the limit
`define BRC_TRAIN_DLY_CYC      16

`endif

// file: common/brc_pkg.sv
/*
  Types for the bridge reset controller.
  Assumes brc_consts.svh for all numeric constants.
*/
package brc_pkg;

  // Graded internal reset scopes, active high
  typedef struct packed {
    logic por;       // everything incl. sticky and aux power machines
    logic fund;      // non-sticky bits and non-aux state machines
    logic dl_down;   // all but sticky and EEPROM-loadable
  } brc_scope_type;

  // Start strobes issued after a reset release
  typedef struct packed {
    logic latch_straps;
    logic eeprom_load;
    logic link_cfg;
    logic train_start;
  } brc_start_type;

  // Power-on sequencing states, Gray coded
  typedef enum logic [1:0] {
    BRC_PWR_WAIT = 2'b00,
    BRC_CLK_WAIT = 2'b01,
    BRC_DELAY    = 2'b11,
    BRC_RUN      = 2'b10
  } brc_pwr_type;

endpackage : brc_pkg

// file: design/brc_reset_ctl.sv
/*
  Bridge reset controller: merges power-on, global, fundamental and hot
  resets into graded internal reset scopes and drives the secondary bus
  reset from those scopes and the software reset bit.
  Assumes one 10 MHz clock; inputs synchronous to it; supply sense is an
  8-bit percent-of-nominal reading; config writes arrive as a 1-bit strobe with 16-bit data.
*/
// Functional notes
// - Hold power-on reset until core supply sense reaches 90 percent.
// - After stable power and clock activity, wait 10 us then release.
// - Power-on reset clears everything and asserts secondary bus reset.
// - Global reset low forces power-on reset asynchronously, any power state.
// - Global reset low clears everything and asserts secondary bus reset.
// - Global reset rise latches straps, starts EEPROM load and link config.
// - Link training starts within 80 ms of global reset release.
// - Fundamental reset low makes internal reset; its rise means power good.
// - Fundamental reset clears non-sticky state and asserts secondary reset.
// - Fundamental reset rise latches straps, starts EEPROM and link config.
// - Link training starts within 80 ms of fundamental reset release.
// - Received hot reset moves the link interface to link-down.
// - Link-down clears non-sticky, non-EEPROM state, asserts secondary reset.
// - Software reset bit 6 at 3Eh drives secondary bus reset.
`timescale 1ns/1ps
`include "brc_consts.svh"

module brc_reset_ctl (
  input  wire logic                  clk_sys,           // 10 MHz system clock
  input  wire logic                  rst_n,             // Async reset, active low
  input  wire logic                  global_reset_n,    // Global reset pin
  input  wire logic                  fundamental_reset_n, // Fundamental reset pin
  input  wire logic [7:0]            core_supply_sense, // Core supply, percent
  input  wire logic                  refclk_active,     // Reference clock detected
  input  wire logic                  hot_reset_rx,      // Training hot reset seen
  input  wire logic                  link_up,           // Link left link-down
  input  wire logic [7:0]            straps_in,         // Static control inputs
  input  wire logic                  eeprom_present,    // EEPROM detected
  input  wire logic                  cfg_wr,            // Config write strobe
  input  wire logic [7:0]            cfg_addr,          // Config byte offset
  input  wire logic [15:0]           cfg_wdata,         // Config write data
  output logic [15:0]                cfg_rdata,         // Config read data
  output brc_pkg::brc_scope_type     reset_scope,       // Internal reset scopes
  output brc_pkg::brc_start_type     start_out,         // Start strobes
  output logic [7:0]                 straps_latched,    // Latched straps
  output logic                       dl_down,           // Link in link-down
  output logic                       secondary_bus_reset_out // Secondary bus reset
);
  import brc_pkg::*;

  //--------------------------------------------------------------
  // Power-on sequencing
  //--------------------------------------------------------------
  brc_pwr_type  pwr_r, pwr_nxt;
  logic [7:0]   wait_r, wait_nxt;
  logic         por_rel_r, por_rel_nxt;
  logic         global_reset_n_meta_r, global_reset_n_sync_r;
  logic         por_clr_n;

  // global reset pin acts without the clock, clearing the release chain
  assign por_clr_n = rst_n && global_reset_n;

  always_ff @(posedge clk_sys or negedge por_clr_n) begin
    if (!por_clr_n) begin
      global_reset_n_meta_r <= 1'b0;
      global_reset_n_sync_r <= 1'b0;
    end else begin
      global_reset_n_meta_r <= 1'b1;
      global_reset_n_sync_r <= global_reset_n_meta_r;
    end
  end

  always_comb begin
    pwr_nxt     = pwr_r;
    wait_nxt    = wait_r;
    por_rel_nxt = 1'b0;
    unique case (pwr_r)
      BRC_PWR_WAIT: begin
        if (core_supply_sense >= `BRC_SUPPLY_GOOD_PCT) pwr_nxt = BRC_CLK_WAIT;
      end
      BRC_CLK_WAIT: begin
        wait_nxt = 8'h00;
        if (refclk_active) pwr_nxt = BRC_DELAY;
      end
      BRC_DELAY: begin
        wait_nxt = wait_r + 8'h01;
        if (wait_r == 8'((`BRC_CLK_WAIT_CYC) - 1)) pwr_nxt = BRC_RUN;
      end
      BRC_RUN: begin
        por_rel_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge por_clr_n) begin
    if (!por_clr_n) begin
      pwr_r     <= BRC_PWR_WAIT;
      wait_r    <= 8'h00;
      por_rel_r <= 1'b0;
    end else begin
      pwr_r     <= pwr_nxt;
      wait_r    <= wait_nxt;
      por_rel_r <= por_rel_nxt;
    end
  end

  //--------------------------------------------------------------
  // Reset scopes, start strobes and link-down
  //--------------------------------------------------------------
  logic          por_act;
  logic          fund_prev_r, fund_prev_nxt;
  logic          dl_r, dl_nxt;
  logic          cnt_run_r, cnt_run_nxt;
  logic [4:0]    tcnt_r, tcnt_nxt;
  brc_scope_type scope_r, scope_nxt;
  brc_start_type start_r, start_nxt;
  logic [7:0]    strap_r, strap_nxt;
  logic          rise;

  assign por_act = !(por_rel_r && global_reset_n_sync_r);

  always_comb begin
    fund_prev_nxt = fundamental_reset_n;
    // rising edge of fundamental reset is power good; same for POR release
    rise          = (fundamental_reset_n && !fund_prev_r && !por_act) ||
                    (por_rel_r && global_reset_n_sync_r && (scope_r.por));
    scope_nxt.por     = por_act;
    // fundamental scope includes the power-on scope
    scope_nxt.fund    = por_act || !fundamental_reset_n;
    // hot reset enters link-down until the link is back up
    dl_nxt = dl_r;
    if (hot_reset_rx) dl_nxt = 1'b1;
    else if (link_up) dl_nxt = 1'b0;
    // link-down scope covers the wider scopes too
    scope_nxt.dl_down = scope_nxt.fund || dl_nxt;
    strap_nxt = strap_r;
    start_nxt = '0;
    cnt_run_nxt = cnt_run_r;
    tcnt_nxt    = tcnt_r;
    if (rise) begin
      // latch straps, EEPROM load, link config
      strap_nxt              = straps_in;
      start_nxt.latch_straps = 1'b1;
      start_nxt.eeprom_load  = eeprom_present;
      start_nxt.link_cfg     = 1'b1;
      cnt_run_nxt            = 1'b1;
      tcnt_nxt               = 5'h00;
    end else if (cnt_run_r) begin
      // training starts a fixed short delay after release
      tcnt_nxt = tcnt_r + 5'h01;
      if (tcnt_r == 5'((`BRC_TRAIN_DLY_CYC) - 1)) begin
        start_nxt.train_start = 1'b1;
        cnt_run_nxt           = 1'b0;
      end
    end
    if (scope_nxt.fund) begin
      cnt_run_nxt = 1'b0;
      tcnt_nxt    = 5'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fund_prev_r <= 1'b0;
      dl_r        <= 1'b0;
      scope_r     <= '1;
      start_r     <= '0;
      strap_r     <= 8'h00;
      cnt_run_r   <= 1'b0;
      tcnt_r      <= 5'h00;
    end else begin
      fund_prev_r <= fund_prev_nxt;
      dl_r        <= dl_nxt;
      // scopes change on the clock edge, or at once when rst_n falls
      scope_r     <= scope_nxt;
      start_r     <= start_nxt;
      strap_r     <= strap_nxt;
      cnt_run_r   <= cnt_run_nxt;
      tcnt_r      <= tcnt_nxt;
    end
  end

  //--------------------------------------------------------------
  // Bridge control register and secondary bus reset
  //--------------------------------------------------------------
  logic [15:0] bctl_r, bctl_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        sbr_r, sbr_nxt;

  always_comb begin
    bctl_nxt = bctl_r;
    if (cfg_wr && cfg_addr == `BRC_BRIDGE_CTL_OFFSET) bctl_nxt = cfg_wdata;
    // register is non-sticky, cleared by every scope
    if (scope_nxt.dl_down) bctl_nxt = `BRC_BRIDGE_CTL_RESET;
    rdata_nxt = (cfg_addr == `BRC_BRIDGE_CTL_OFFSET) ? bctl_r : 16'h0000;
    // OR of scopes and software reset bit
    sbr_nxt = scope_nxt.por || scope_nxt.fund || scope_nxt.dl_down ||
              bctl_nxt[`BRC_SEC_RESET_BIT];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bctl_r  <= `BRC_BRIDGE_CTL_RESET;
      rdata_r <= 16'h0000;
      sbr_r   <= 1'b1;
    end else begin
      bctl_r  <= bctl_nxt;
      rdata_r <= rdata_nxt;
      sbr_r   <= sbr_nxt;
    end
  end

  assign cfg_rdata               = rdata_r;
  assign reset_scope             = scope_r;
  assign start_out               = start_r;
  assign straps_latched          = strap_r;
  assign dl_down                 = dl_r;
  assign secondary_bus_reset_out = sbr_r;

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  property p_por_sbr;
    @(posedge clk_sys) disable iff (!rst_n) scope_r.por |-> sbr_r;
  endproperty
  a_por_sbr: assert property (p_por_sbr) else $error("sbr low in por");

  property p_fund_sbr;
    @(posedge clk_sys) disable iff (!rst_n)
      !fundamental_reset_n |=> scope_r.fund && sbr_r;
  endproperty
  a_fund_sbr: assert property (p_fund_sbr) else $error("fund reset missed");

  property p_hot_dl;
    @(posedge clk_sys) disable iff (!rst_n)
      hot_reset_rx |=> dl_r && scope_r.dl_down && sbr_r;
  endproperty
  a_hot_dl: assert property (p_hot_dl) else $error("hot reset missed");

  property p_sw_sbr;
    @(posedge clk_sys) disable iff (!rst_n)
      bctl_r[`BRC_SEC_RESET_BIT] |-> sbr_r;
  endproperty
  a_sw_sbr: assert property (p_sw_sbr) else $error("sw reset not driven");

  property p_sbr_or;
    @(posedge clk_sys) disable iff (!rst_n)
      sbr_r == (scope_r.dl_down || bctl_r[`BRC_SEC_RESET_BIT]);
  endproperty
  a_sbr_or: assert property (p_sbr_or) else $error("sbr not OR");

  property p_low_supply;
    @(posedge clk_sys) disable iff (!rst_n)
      (pwr_r == BRC_PWR_WAIT) |=> scope_r.por;
  endproperty
  a_low_supply: assert property (p_low_supply) else $error("por early");

  property p_delay;
    @(posedge clk_sys) disable iff (!rst_n || !global_reset_n)
      (pwr_r == BRC_CLK_WAIT && refclk_active) |=> (pwr_r == BRC_DELAY)[*8];
  endproperty
  a_delay: assert property (p_delay) else $error("clock wait short");

  // cycles since link config with no fundamental scope
  logic [4:0] trn_wait_r, trn_wait_nxt;

  always_comb begin
    trn_wait_nxt = 5'h00;
    if (!scope_nxt.fund && start_r.link_cfg) begin
      trn_wait_nxt = 5'h01;
    end else if (!scope_nxt.fund && trn_wait_r != 5'h00 &&
                 trn_wait_r != 5'(`BRC_TRAIN_DLY_CYC)) begin
      trn_wait_nxt = trn_wait_r + 5'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) trn_wait_r <= 5'h00;
    else        trn_wait_r <= trn_wait_nxt;
  end

  property p_train;
    @(posedge clk_sys) disable iff (!rst_n)
      (trn_wait_r == 5'(`BRC_TRAIN_DLY_CYC) && !scope_nxt.fund) |-> start_r.train_start;
  endproperty
  a_train: assert property (p_train) else $error("training late");

  property p_strap;
    @(posedge clk_sys) disable iff (!rst_n)
      start_r.latch_straps |-> start_r.link_cfg && strap_r == $past(straps_in);
  endproperty
  a_strap: assert property (p_strap) else $error("straps not latched");

endmodule : brc_reset_ctl

// file: testbench/brc_host_model.sv
/*
  Upstream host model: ramps the core supply, starts the reference clock,
  then holds the fundamental reset for HOLD_CYC cycles.
  Assumes the bench owns power_req and fund_req.
*/
`timescale 1ns/1ps
module brc_host_model #(
  parameter int HOLD_CYC = 1000
) (
  input  wire logic  clk_sys,             // System clock
  input  wire logic  power_req,           // Power applied when high
  input  wire logic  fund_req,            // Extra fundamental reset request
  output logic [7:0] core_supply_sense,   // Supply, percent of nominal
  output logic       refclk_active,       // Reference clock running
  output logic       fundamental_reset_n  // Fundamental reset, active low
);
  int hold_cnt = 0;
  initial begin
    core_supply_sense = 8'h00;
    refclk_active = 1'b0;
    fundamental_reset_n = 1'b0;
  end
  always @(negedge clk_sys) begin
    if (power_req) begin
      if (core_supply_sense < 8'h64)
        core_supply_sense <= core_supply_sense + 8'h01;
      else
        refclk_active <= 1'b1;
      if (refclk_active && hold_cnt < HOLD_CYC)
        hold_cnt <= hold_cnt + 1;
      fundamental_reset_n <= (hold_cnt >= HOLD_CYC) && !fund_req;
    end else if (fundamental_reset_n) begin
      fundamental_reset_n <= 1'b0;
    end else if (refclk_active) begin
      refclk_active <= 1'b0;
    end else begin
      core_supply_sense <= 8'h00;
      hold_cnt <= 0;
    end
  end
endmodule : brc_host_model

// file: testbench/testbench.sv
/*
  Bench for the bridge reset controller: host model on the fundamental
  reset side, config accesses and reset pins driven at falling edges.
  Assumes brc_pkg and the host model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import brc_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, global_reset_n = 1'b1, hot_reset_rx = 1'b0;
  logic link_up = 1'b0, eeprom_present = 1'b1, cfg_wr = 1'b0, power_req = 1'b0;
  logic fund_req = 1'b0, refclk_active, fundamental_reset_n, dl_down, secondary_bus_reset_out;
  logic [7:0] straps_in = 8'ha5, cfg_addr = 8'h00, core_supply_sense, straps_latched;
  logic [15:0] cfg_wdata = 16'h0000, cfg_rdata, rd;
  brc_scope_type reset_scope;
  brc_start_type start_out;
  int fails = 0, comparisons = 0, cycles = 0, n;

  always #50 clk_sys = ~clk_sys;

  brc_host_model #(.HOLD_CYC(1000)) host (.clk_sys, .power_req, .fund_req,
    .core_supply_sense, .refclk_active, .fundamental_reset_n);
  brc_reset_ctl DUT (.clk_sys, .rst_n, .global_reset_n, .fundamental_reset_n,
    .core_supply_sense, .refclk_active, .hot_reset_rx, .link_up, .straps_in,
    .eeprom_present, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata, .reset_scope,
    .start_out, .straps_latched, .dl_down, .secondary_bus_reset_out);

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  // Waits at falling edges until the chosen condition holds
  task automatic wait_sel(input int sel, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    forever begin
      case (sel)
        0: hit = start_out.latch_straps;
        1: hit = start_out.train_start;
        2: hit = !reset_scope.por;
        default: hit = refclk_active;
      endcase
      if (hit === 1'b1 || cnt >= lim)
        break;
      @(negedge clk_sys);
      cnt++;
    end
    if (hit !== 1'b1) chk(1'b0, "wait limit reached");
  endtask : wait_sel

  task automatic cfg_write(input logic [7:0] a, input logic [15:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
  endtask : cfg_write

  task automatic cfg_read(input logic [7:0] a, output logic [15:0] d);
    cfg_addr = a;
    @(negedge clk_sys);
    d = cfg_rdata;
  endtask : cfg_read

  // Start strobes after a reset release, then training start
  task automatic chk_release(input int lim, input logic [7:0] s);
    wait_sel(0, lim, n);
    chk(start_out === {1'b1, eeprom_present, 2'b10}, "start strobes");
    chk(straps_latched === s, "straps latched");
    wait_sel(1, 30, n);
    chk(start_out.train_start === 1'b1 && n >= 15 && n <= 18, "training start");
  endtask : chk_release

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles >= 5000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    power_req = 1'b1;
    while (core_supply_sense < 8'h5a) begin
      chk(reset_scope.por === 1'b1 && secondary_bus_reset_out === 1'b1, "por ramp");
      @(negedge clk_sys);
    end
    wait_sel(3, 200, n);
    wait_sel(2, 200, n);
    chk(n >= 100 && n <= 105, "por release delay");
    repeat (30) @(negedge clk_sys);
    straps_in = 8'h3c;
    chk(reset_scope.fund === 1'b1 && secondary_bus_reset_out === 1'b1, "fund held");
    chk_release(1100, 8'h3c);
    chk(reset_scope === 3'b000 && secondary_bus_reset_out === 1'b0, "all clear");
    cfg_write(8'h3e, 16'h0040);
    chk(secondary_bus_reset_out === 1'b1, "software reset set");
    cfg_read(8'h3e, rd);
    chk(rd === 16'h0040, "control readback");
    cfg_write(8'h3c, 16'h0000);
    cfg_read(8'h3c, rd);
    chk(rd === 16'h0000 && secondary_bus_reset_out === 1'b1, "unmapped offset");
    cfg_write(8'h3e, 16'hffbf);
    cfg_read(8'h3e, rd);
    chk(rd === 16'hffbf && secondary_bus_reset_out === 1'b0, "software reset clear");
    hot_reset_rx = 1'b1;
    @(negedge clk_sys);
    hot_reset_rx = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(dl_down === 1'b1 && reset_scope.dl_down === 1'b1, "link down");
    cfg_read(8'h3e, rd);
    chk(rd === 16'h0000 && secondary_bus_reset_out === 1'b1, "link down clears");
    link_up = 1'b1;
    @(negedge clk_sys);
    link_up = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(dl_down === 1'b0 && secondary_bus_reset_out === 1'b0, "link up");
    fund_req = 1'b1;
    eeprom_present = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(reset_scope.fund === 1'b1 && reset_scope.por === 1'b0, "fund scope");
    chk(secondary_bus_reset_out === 1'b1, "fund drives reset out");
    straps_in = 8'h96;
    fund_req = 1'b0;
    chk_release(10, 8'h96);
    cfg_write(8'h3e, 16'h0001);
    straps_in = 8'h69;
    global_reset_n = 1'b0;
    @(negedge clk_sys);
    chk(reset_scope.por === 1'b1 && secondary_bus_reset_out === 1'b1, "global low");
    repeat (3) @(negedge clk_sys);
    global_reset_n = 1'b1;
    chk_release(300, 8'h69);
    cfg_read(8'h3e, rd);
    chk(rd === 16'h0000, "global clears control");
    report_and_stop();
  end
endmodule : testbench
